// File: hdl/cc_module.sv
/*
  One capture/compare module: line filter, mode decode, capture, match,
  toggle, frequency and pulse-width outputs.
  Assumes count, adv and overflow pulses come registered from the counter,
  and that the owner applies the load requests to its compare bytes.
*/
`timescale 1ns/1ps
`default_nettype none

module cc_module
  import counter_array_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic line_in,
  input wire logic active,
  input wire logic adv,
  input wire logic low_ovf,
  input wire logic full_ovf,
  input wire logic [7:0] mode,
  input wire logic [7:0] cmp_low,
  input wire logic [7:0] cmp_high,
  input wire logic [15:0] count,
  output logic line_out,
  output logic line_oe,
  output logic event_pulse,
  output logic load_low,
  output logic load_high,
  output logic [15:0] load_value
);

  cc_state_type s;
  cc_state_type n;
  cc_mode_type md;
  logic stable;
  logic rise;
  logic fall;
  logic hit16;
  logic hit8;

  // ****************************************************************
  // Mode decode
  // ****************************************************************
  always_comb begin
    md = CC_OFF;
    if ((mode[`MM_RISE] | mode[`MM_FALL]) & ~mode[`MM_MATCH] &
        ~mode[`MM_TOGGLE] & ~mode[`MM_PULSE]) begin
      md = CC_CAPTURE;
    end else if (mode[`MM_COMPARE] & ~mode[`MM_RISE] & ~mode[`MM_FALL]) begin
      if (mode[`MM_TOGGLE] & mode[`MM_PULSE]) begin
        md = CC_FREQ;
      end else if (mode[`MM_PULSE] & ~mode[`MM_TOGGLE]) begin
        md = mode[`MM_WIDE] ? CC_PWM16 : CC_PWM8;
      end else if (mode[`MM_MATCH] & mode[`MM_TOGGLE]) begin
        md = CC_HSO;
      end else if (mode[`MM_MATCH]) begin
        md = CC_TIMER;
      end
    end
  end

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    n = s;
    n.event_pulse = 1'b0;
    n.load_low = 1'b0;
    n.load_high = 1'b0;
    n.sync[0] = line_in;
    n.sync[1] = s.sync[0];
    n.sync[2] = s.sync[1];
    // A level counts only once it has held for two samples
    stable = (s.sync[2] == s.sync[1]);
    if (stable) begin
      n.level = s.sync[1];
    end
    rise = stable & s.sync[1] & ~s.level;
    fall = stable & ~s.sync[1] & s.level;
    hit16 = adv & (count == {cmp_high, cmp_low});
    hit8 = adv & (count[7:0] == cmp_low);
    case (md)
      CC_CAPTURE: begin
        if (active & ((rise & mode[`MM_RISE]) | (fall & mode[`MM_FALL]))) begin
          n.event_pulse = 1'b1;
          n.load_low = 1'b1;
          n.load_high = 1'b1;
          n.value = count;
        end
      end
      CC_TIMER: begin
        if (hit16) begin
          n.event_pulse = 1'b1;
        end
      end
      CC_HSO: begin
        if (hit16) begin
          n.event_pulse = 1'b1;
          n.line = ~s.line;
        end
      end
      CC_FREQ: begin
        if (hit8) begin
          n.line = ~s.line;
          n.load_low = 1'b1;
          // An offset of zero wraps the byte, which acts as 256
          n.value = {8'h00, 8'(cmp_low + cmp_high)};
        end
      end
      CC_PWM8: begin
        if (low_ovf) begin
          n.line = 1'b0;
          n.load_low = 1'b1;
          n.value = {8'h00, cmp_high};
        end
        // Set after clear, so a compare byte of zero gives full duty
        if (hit8) begin
          n.line = 1'b1;
          n.event_pulse = mode[`MM_MATCH];
        end
      end
      CC_PWM16: begin
        if (full_ovf) begin
          n.line = 1'b0;
        end
        if (hit16) begin
          n.line = 1'b1;
          n.event_pulse = mode[`MM_MATCH];
        end
      end
      default: begin
        n.line = 1'b0;
      end
    endcase
    n.oe = (md == CC_HSO) | (md == CC_FREQ) | (md == CC_PWM8) |
           (md == CC_PWM16);
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign line_out = s.line;
  assign line_oe = s.oe;
  assign event_pulse = s.event_pulse;
  assign load_low = s.load_low;
  assign load_high = s.load_high;
  assign load_value = s.value;

endmodule

`default_nettype wire

// File: hdl/counter_array.sv
/*
  Counter array: 16-bit timebase counter, five capture/compare modules,
  watchdog role of module 4, and an Avalon-MM register slave.
  Assumes one 25 MHz clock, synchronous active-low reset, and pins that
  may change at any time; interrupt enables come from same-clock logic.
*/
// The address map and the Avalon-MM register port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

module counter_array
  import counter_array_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic external_count_input,
  input wire logic timer0_overflow,
  input wire logic ext_osc_clk,
  input wire logic cpu_idle,
  input wire logic global_irq_enable,
  input wire logic array_irq_enable,
  input wire logic [`NUM_MODULES-1:0] module_line_in,
  output logic [`NUM_MODULES-1:0] module_line_out,
  output logic [`NUM_MODULES-1:0] module_line_oe,
  output logic irq,
  output logic watchdog_reset
);

  main_state_type s;
  main_state_type n;
  logic wd_en;
  logic halt;
  logic tick;
  logic go;
  logic osc_rise;
  logic in_mm;
  logic in_cmp;
  logic [7:0] moff;
  logic [7:0] coff;
  logic [2:0] mi;
  logic [2:0] ci;
  logic [7:0] wd;
  logic [7:0] rd_byte;
  logic [`NUM_MODULES-1:0] irq_en;
  logic [`NUM_MODULES-1:0] ev_p;
  logic [`NUM_MODULES-1:0] ld_lo;
  logic [`NUM_MODULES-1:0] ld_hi;
  logic [`NUM_MODULES-1:0][15:0] ld_val;
  logic [`NUM_MODULES-1:0][7:0] mode_to_cc;

  // ****************************************************************
  // Capture/compare modules
  // ****************************************************************
  genvar g;
  generate
    for (g = 0; g < `NUM_MODULES; g = g + 1) begin : gen_cc
      cc_module u_cc (
        .clk(clk),
        .nrst(nrst),
        .line_in(module_line_in[g]),
        .active(~halt),
        .adv(s.adv),
        .low_ovf(s.low_ovf),
        .full_ovf(s.full_ovf),
        .mode(mode_to_cc[g]),
        .cmp_low(s.cmp_lo[g]),
        .cmp_high(s.cmp_hi[g]),
        .count(s.count),
        .line_out(module_line_out[g]),
        .line_oe(module_line_oe[g]),
        .event_pulse(ev_p[g]),
        .load_low(ld_lo[g]),
        .load_high(ld_hi[g]),
        .load_value(ld_val[g])
      );
    end
  endgenerate

  // ****************************************************************
  // Address decode and read mux
  // ****************************************************************
  always_comb begin
    wd = writedata[7:0];
    moff = address - `ADDR_MMODE_BASE;
    coff = address - `ADDR_CMP_BASE;
    mi = moff[4:2];
    ci = coff[5:3];
    in_mm = (address >= `ADDR_MMODE_BASE) && (address < `ADDR_MMODE_END);
    in_cmp = (address >= `ADDR_CMP_BASE) && (address < `ADDR_CMP_END);
    rd_byte = 8'h00;
    if (address == `ADDR_COUNT_LOW) begin
      rd_byte = s.count[7:0];
    end else if (address == `ADDR_COUNT_HIGH) begin
      rd_byte = s.snap;
    end else if (address == `ADDR_ARRAY_MODE) begin
      rd_byte = s.mode_reg;
    end else if (address == `ADDR_ARRAY_CONTROL) begin
      rd_byte = {s.ovf_flag, s.run, 1'b0, s.ev_flag};
    end else if (in_mm && address[1:0] == 2'h0) begin
      rd_byte = s.mmode[mi];
    end else if (in_cmp && address[1:0] == 2'h0) begin
      rd_byte = coff[2] ? s.cmp_hi[ci] : s.cmp_lo[ci];
    end
  end

  // ****************************************************************
  // Timebase and counter controls
  // ****************************************************************
  always_comb begin
    wd_en = s.mode_reg[`MD_WD_ENABLE] | s.mode_reg[`MD_WD_LOCK];
    halt = s.mode_reg[`MD_IDLE_SUSPEND] & cpu_idle;
    osc_rise = s.osc_s[1] & ~s.osc_s[2];
    for (int i = 0; i < `NUM_MODULES; i++) begin
      irq_en[i] = s.mmode[i][`MM_IRQ_EN];
      mode_to_cc[i] = s.mmode[i];
    end
    // Watchdog owns module 4, so its compare logic is parked
    if (wd_en) begin
      mode_to_cc[`WD_MODULE] = 8'h00;
    end
    case (s.mode_reg[`MD_TB_MSB:`MD_TB_LSB])
      TB_DIV12: tick = (s.div == `DIV12_LAST);
      TB_DIV4: tick = (s.div[1:0] == `DIV4_LAST);
      TB_TIMER0: tick = s.t0_s[1] & ~s.t0_s[2];
      TB_EVENT_PIN: tick = ~s.eci_s[1] & s.eci_s[2];
      TB_SYSCLK: tick = 1'b1;
      TB_OSC_DIV8: tick = osc_rise & (s.osc_div == `OSC_DIV_LAST);
      default: tick = 1'b0;
    endcase
    go = tick & (s.run | wd_en) & ~halt;
  end

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    n = s;
    n.adv = 1'b0;
    n.low_ovf = 1'b0;
    n.full_ovf = 1'b0;
    n.wd_reset = 1'b0;

    // Count, timer-0 and oscillator pins pass two flops before any decision reads them
    n.eci_s = {s.eci_s[1:0], external_count_input};
    n.t0_s = {s.t0_s[1:0], timer0_overflow};
    n.osc_s = {s.osc_s[1:0], ext_osc_clk};
    n.div = (s.div == `DIV12_LAST) ? 4'h0 : 4'(s.div + 4'h1);
    if (osc_rise) begin
      n.osc_div = 3'(s.osc_div + 3'h1);
    end

    if (go) begin
      n.count = 16'(s.count + 16'h0001);
      n.adv = 1'b1;
      n.low_ovf = (s.count[7:0] == 8'hff);
      n.full_ovf = (s.count == 16'hffff);
      // Watchdog bites when the low byte wraps on a high-byte match
      n.wd_reset = wd_en & (s.count[7:0] == 8'hff) &
                   (s.count[15:8] == s.cmp_hi[`WD_MODULE]);
    end

    // Hardware loads from the modules
    for (int i = 0; i < `NUM_MODULES; i++) begin
      if (ld_lo[i]) begin
        n.cmp_lo[i] = ld_val[i][7:0];
      end
      if (ld_hi[i]) begin
        n.cmp_hi[i] = ld_val[i][15:8];
      end
    end

    // Avalon slave: answer one cycle after the request is seen
    case (s.bus)
      BUS_IDLE: begin
        if (read | write) begin
          n.bus = BUS_ACK;
          n.waitrequest = 1'b0;
          n.readdata = {24'h000000, rd_byte};
          // Snapshot at the same edge as the low byte, so the pair agrees
          if (read && address == `ADDR_COUNT_LOW) begin
            n.snap = s.count[15:8];
          end
        end
      end
      BUS_ACK: begin
        n.bus = BUS_IDLE;
        n.waitrequest = 1'b1;
        if (write && byteenable[0]) begin
          if (address == `ADDR_COUNT_LOW && !wd_en) begin
            n.count[7:0] = wd;
          end else if (address == `ADDR_COUNT_HIGH && !wd_en) begin
            n.count[15:8] = wd;
          end else if (address == `ADDR_ARRAY_MODE) begin
            n.mode_reg[`MD_OVF_IE] = wd[`MD_OVF_IE];
            n.mode_reg[`MD_WD_ENABLE] = wd[`MD_WD_ENABLE];
            n.mode_reg[`MD_WD_LOCK] = s.mode_reg[`MD_WD_LOCK] |
                                      wd[`MD_WD_LOCK];
            if (!wd_en) begin
              n.mode_reg[`MD_TB_MSB:`MD_TB_LSB] = wd[`MD_TB_MSB:`MD_TB_LSB];
              n.mode_reg[`MD_IDLE_SUSPEND] = wd[`MD_IDLE_SUSPEND];
            end
          end else if (address == `ADDR_ARRAY_CONTROL) begin
            n.ovf_flag = wd[`CN_OVF_FLAG];
            n.run = wd[`CN_RUN];
            n.ev_flag = wd[`NUM_MODULES-1:0];
            n.wd_reset = n.wd_reset | (wd_en & wd[`CN_WD_FORCE]);
          end else if (in_mm && address[1:0] == 2'h0) begin
            if (!(wd_en && mi == 3'(`WD_MODULE))) begin
              n.mmode[mi] = wd;
            end
          end else if (in_cmp && address[1:0] == 2'h0) begin
            if (!coff[2]) begin
              n.cmp_lo[ci] = wd;
              n.mmode[ci][`MM_COMPARE] = 1'b0;
            end else begin
              n.cmp_hi[ci] = wd;
              n.mmode[ci][`MM_COMPARE] = 1'b1;
              // A watchdog kick reloads the deadline from counter high
              if (wd_en && ci == 3'(`WD_MODULE)) begin
                n.cmp_hi[ci] = 8'(s.count[15:8] + s.cmp_lo[ci]);
              end
            end
          end
        end
      end
      default: begin
        n.bus = BUS_IDLE;
        n.waitrequest = 1'b1;
      end
    endcase

    // Hardware sets come last so they beat a same-cycle clear
    if (go && s.count == 16'hffff) begin
      n.ovf_flag = 1'b1;
    end
    for (int i = 0; i < `NUM_MODULES; i++) begin
      if (ev_p[i]) begin
        n.ev_flag[i] = 1'b1;
      end
    end

    n.irq = global_irq_enable & array_irq_enable &
            ((n.ovf_flag & n.mode_reg[`MD_OVF_IE]) |
             (|(n.ev_flag & irq_en)));
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (!nrst) begin
      s <= '0;
      s.bus <= BUS_IDLE;
      s.waitrequest <= 1'b1;
      s.mode_reg <= `MODE_RESET;
    end else begin
      s <= n;
    end
  end

  assign readdata = s.readdata;
  assign waitrequest = s.waitrequest;
  assign irq = s.irq;
  assign watchdog_reset = s.wd_reset;

endmodule

`default_nettype wire

// File: hdl/counter_array_map.svh
/*
  Register offsets, bit positions, reset values and divider counts of the
  counter array.
  Assumes byte addresses on a 32-bit Avalon-MM slave, one register a word.
*/
`ifndef COUNTER_ARRAY_MAP_SVH
`define COUNTER_ARRAY_MAP_SVH

// ****************************************************************
// Register offsets (byte addresses)
// ****************************************************************
`define ADDR_COUNT_LOW 8'h00
`define ADDR_COUNT_HIGH 8'h04
`define ADDR_ARRAY_MODE 8'h08
`define ADDR_ARRAY_CONTROL 8'h0c
`define ADDR_MMODE_BASE 8'h10
`define ADDR_MMODE_END 8'h24
`define ADDR_CMP_BASE 8'h30
`define ADDR_CMP_END 8'h58

// ****************************************************************
// Array mode register fields
// ****************************************************************
`define MD_OVF_IE 0
`define MD_TB_LSB 1
`define MD_TB_MSB 3
`define MD_WD_LOCK 5
`define MD_WD_ENABLE 6
`define MD_IDLE_SUSPEND 7
`define MODE_RESET 8'h40

// ****************************************************************
// Array control register fields
// ****************************************************************
`define CN_OVF_FLAG 7
`define CN_RUN 6
`define CN_WD_FORCE 4

// ****************************************************************
// Module mode register fields
// ****************************************************************
`define MM_WIDE 7
`define MM_COMPARE 6
`define MM_RISE 5
`define MM_FALL 4
`define MM_MATCH 3
`define MM_TOGGLE 2
`define MM_PULSE 1
`define MM_IRQ_EN 0

// ****************************************************************
// Sizes and divider counts
// ****************************************************************
`define NUM_MODULES 5
`define WD_MODULE 4
`define DIV12_LAST 4'hb
`define DIV4_LAST 2'h3
`define OSC_DIV_LAST 3'h7

`endif

// File: hdl/counter_array_pkg.sv
/*
  Types shared by the counter array and its capture/compare modules.
  Assumes counter_array_map.svh is on the include path.
*/
`include "counter_array_map.svh"

package counter_array_pkg;

  typedef enum logic [2:0] {
    TB_DIV12 = 3'b000,
    TB_DIV4 = 3'b001,
    TB_TIMER0 = 3'b010,
    TB_EVENT_PIN = 3'b011,
    TB_SYSCLK = 3'b100,
    TB_OSC_DIV8 = 3'b101
  } timebase_type;

  typedef enum logic {
    BUS_IDLE = 1'b0,
    BUS_ACK = 1'b1
  } bus_state_type;

  typedef enum logic [2:0] {
    CC_OFF = 3'b000,
    CC_CAPTURE = 3'b001,
    CC_TIMER = 3'b010,
    CC_HSO = 3'b011,
    CC_FREQ = 3'b100,
    CC_PWM8 = 3'b101,
    CC_PWM16 = 3'b110
  } cc_mode_type;

  typedef struct packed {
    logic [2:0] sync;
    logic level;
    logic line;
    logic oe;
    logic event_pulse;
    logic load_low;
    logic load_high;
    logic [15:0] value;
  } cc_state_type;

  typedef struct packed {
    bus_state_type bus;
    logic waitrequest;
    logic [31:0] readdata;
    logic [15:0] count;
    logic [7:0] snap;
    logic [7:0] mode_reg;
    logic run;
    logic ovf_flag;
    logic [`NUM_MODULES-1:0] ev_flag;
    logic [`NUM_MODULES-1:0][7:0] mmode;
    logic [`NUM_MODULES-1:0][7:0] cmp_lo;
    logic [`NUM_MODULES-1:0][7:0] cmp_hi;
    logic [3:0] div;
    logic [2:0] osc_div;
    logic [2:0] eci_s;
    logic [2:0] t0_s;
    logic [2:0] osc_s;
    logic adv;
    logic low_ovf;
    logic full_ovf;
    logic irq;
    logic wd_reset;
  } main_state_type;

endpackage

// File: tb/counter_array_checker.sv
/*
  Port assertions: bus handshake, interrupt gating, watchdog pulse.
  Assumes one clock domain; bound to the top module below.
*/
`timescale 1ns/1ps
`default_nettype none

module counter_array_checker (
  input wire logic clk,
  input wire logic nrst,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  input wire logic global_irq_enable,
  input wire logic array_irq_enable,
  input wire logic [4:0] module_line_oe,
  input wire logic irq,
  input wire logic watchdog_reset
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  // ********
  // Handshake
  // ********
  a_wait_single: assert property ($fell(waitrequest) |=> waitrequest)
    else $error("waitrequest low too long");
  a_wait_answer: assert property (
    (read || write) && waitrequest |=> !waitrequest)
    else $error("no answer one cycle after request");
  a_wait_idle: assert property (!read && !write |=> waitrequest)
    else $error("answer without request");
  a_upper_zero: assert property (
    !waitrequest |-> readdata[31:8] == 24'h000000)
    else $error("upper read data not zero");

  // ********
  // Interrupts and outputs
  // ********
  a_irq_global: assert property (irq |-> $past(global_irq_enable))
    else $error("irq without global enable");
  a_irq_hold: assert property (!global_irq_enable [*2] |-> !irq)
    else $error("irq while globally disabled");
  a_irq_array: assert property ($fell(array_irq_enable) |=> !irq)
    else $error("irq after array enable dropped");
  a_wd_pulse: assert property (watchdog_reset |=> !watchdog_reset)
    else $error("watchdog pulse longer than one cycle");
  a_oe_by_write: assert property (
    $changed(module_line_oe) |-> $past(write, 2))
    else $error("output enable changed without a write");
endmodule

bind counter_array counter_array_checker u_checker (
  .clk, .nrst, .read, .write, .readdata, .waitrequest,
  .global_irq_enable, .array_irq_enable, .module_line_oe,
  .irq, .watchdog_reset
);

`default_nettype wire

// File: tb/pin_source.sv
/*
  Far-side pin model: event pin, timer-0 overflow and oscillator.
  Assumes the bench clock; all three pins run free.
*/
`timescale 1ns/1ps
`default_nettype none

module pin_source (
  input wire logic clk,
  output logic ev_pin,
  output logic t0_ovf,
  output logic osc
);
  int n = 0;

  initial {ev_pin, t0_ovf, osc} = 3'b100;

  // Falls every 6 clocks, safely slower than a quarter of clk
  always @(posedge clk) begin
    n <= n + 1;
    ev_pin <= (n % 6) < 3;
    t0_ovf <= (n % 10) == 0;
    osc <= (n % 6) < 3;
  end
endmodule

`default_nettype wire

// File: tb/tb_counter_array.sv
/*
  Self-checking bench: Avalon tasks and scenario sequence.
  Assumes pin_source drives the timebase pins; checker bound.
*/
`timescale 1ns/1ps
`default_nettype none

module tb_counter_array;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] address = 8'h00;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [31:0] readdata;
  logic waitrequest, ev_pin, t0_ovf, osc, irq, watchdog_reset;
  logic cpu_idle = 1'b0;
  logic gie = 1'b1;
  logic aie = 1'b1;
  logic [4:0] lines = 5'h00;
  logic [4:0] module_line_out, module_line_oe;
  logic [7:0] q, h;
  logic [7:0] tbx [8] = '{8'h14, 8'h3c, 8'h18, 8'h28, 8'hf0, 8'h05,
                          8'h00, 8'h00};
  logic [7:0] cm [3] = '{8'h21, 8'h11, 8'h31};
  int num_errors = 0;
  int total_checks = 0;
  int cyc = 0;
  int n;

  counter_array u_dut (
    .clk, .nrst, .address, .read, .write, .writedata,
    .byteenable(4'h1), .readdata, .waitrequest,
    .external_count_input(ev_pin), .timer0_overflow(t0_ovf),
    .ext_osc_clk(osc), .cpu_idle, .global_irq_enable(gie),
    .array_irq_enable(aie), .module_line_in(lines),
    .module_line_out, .module_line_oe, .irq, .watchdog_reset
  );
  pin_source u_pins (.clk, .ev_pin, .t0_ovf, .osc);

  always #20 clk = ~clk;

  // ********
  // Tasks
  // ********
  task automatic finish_test();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Whole run is under 20k cycles; a hang lands here
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      num_errors++;
      finish_test();
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic near(input int got, input int exp, input int tol);
    chk({7'h0, got >= exp - tol && got <= exp + tol}, 8'h01);
  endtask

  task automatic bus(input logic w, input logic [7:0] a, d,
                     output logic [7:0] r);
    @(posedge clk);
    address <= a;
    write <= w;
    read <= !w;
    writedata <= {24'h0, d};
    do @(posedge clk); while (waitrequest !== 1'b0);
    r = readdata[7:0];
    read <= 1'b0;
    write <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, d);
    bus(1'b1, a, d, q);
  endtask

  task automatic rc(input logic [7:0] a, e);
    bus(1'b0, a, 8'h00, q);
    chk(q, e);
  endtask

  task automatic setcnt(input logic [15:0] v);
    wr(8'h0c, 8'h00);
    wr(8'h00, v[7:0]);
    wr(8'h04, v[15:8]);
  endtask

  task automatic await_line(input int m, output int k);
    logic l0;
    l0 = module_line_out[m];
    k = 0;
    while (module_line_out[m] === l0) begin
      @(posedge clk);
      k++;
    end
  endtask

  // ********
  // Scenarios
  // ********
  initial begin
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    n = cyc;
    rc(8'h08, 8'h40);
    while (watchdog_reset !== 1'b1) @(posedge clk);
    near(cyc - n, 3072, 24);
    wr(8'h08, 8'h48);
    rc(8'h08, 8'h40);
    wr(8'h08, 8'h00);
    rc(8'h08, 8'h00);
    for (int i = 0; i < 8; i++) begin
      setcnt(16'h0000);
      wr(8'h08, {4'h0, 3'(i), 1'b0});
      wr(8'h0c, 8'h40);
      repeat (240) @(posedge clk);
      wr(8'h0c, 8'h00);
      bus(1'b0, 8'h00, 8'h00, q);
      near(q, tbx[i], 4);
    end
    setcnt(16'h12f0);
    wr(8'h08, 8'h08);
    wr(8'h0c, 8'h40);
    bus(1'b0, 8'h00, 8'h00, q);
    repeat (40) @(posedge clk);
    bus(1'b0, 8'h04, 8'h00, h);
    chk(h, q < 8'hf0 ? 8'h13 : 8'h12);
    setcnt(16'hffe0);
    wr(8'h08, 8'h09);
    wr(8'h0c, 8'h40);
    while (irq !== 1'b1) @(posedge clk);
    rc(8'h0c, 8'hc0);
    gie <= 1'b0;
    repeat (2) @(posedge clk);
    chk({7'h0, irq}, 8'h00);
    gie <= 1'b1;
    aie <= 1'b0;
    repeat (2) @(posedge clk);
    chk({7'h0, irq}, 8'h00);
    aie <= 1'b1;
    rc(8'h0c, 8'hc0);
    wr(8'h0c, 8'h40);
    rc(8'h0c, 8'h40);
    for (int m = 0; m < 3; m++) begin
      lines[m] <= (m == 1);
      wr(8'h08, 8'h00);
      setcnt({8'h40 + 8'(m), 8'h21});
      wr(8'h10 + 8'(4 * m), cm[m]);
      repeat (4) @(posedge clk);
      lines[m] <= (m != 1);
      repeat (10) @(posedge clk);
      rc(8'h30 + 8'(8 * m), 8'h21);
      rc(8'h34 + 8'(8 * m), 8'h40 + 8'(m));
      rc(8'h0c, 8'h01 << m);
      chk({7'h0, irq}, 8'h01);
    end
    // One-cycle glitch must be filtered out
    wr(8'h0c, 8'h00);
    lines[0] <= 1'b0;
    @(posedge clk);
    lines[0] <= 1'b1;
    repeat (10) @(posedge clk);
    rc(8'h0c, 8'h00);
    setcnt(16'h0100);
    wr(8'h1c, 8'h49);
    wr(8'h48, 8'h20);
    rc(8'h1c, 8'h09);
    wr(8'h4c, 8'h01);
    rc(8'h1c, 8'h49);
    wr(8'h0c, 8'h40);
    while (irq !== 1'b1) @(posedge clk);
    rc(8'h0c, 8'h48);
    wr(8'h1c, 8'h4c);
    wr(8'h48, 8'h40);
    wr(8'h4c, 8'h01);
    await_line(3, n);
    chk({7'h0, module_line_oe[3]}, 8'h01);
    bus(1'b0, 8'h00, 8'h00, q);
    near(q, 8'h40, 1);
    wr(8'h08, 8'h08);
    wr(8'h10, 8'h46);
    wr(8'h30, 8'h00);
    wr(8'h34, 8'h05);
    await_line(0, n);
    await_line(0, n);
    chk(8'(n), 8'h05);
    wr(8'h14, 8'h42);
    wr(8'h38, 8'hc0);
    wr(8'h3c, 8'hc0);
    repeat (256) @(posedge clk);
    n = 0;
    repeat (256) begin
      @(posedge clk);
      n += module_line_out[1];
    end
    near(n, 64, 2);
    wr(8'h08, 8'h88);
    cpu_idle <= 1'b1;
    bus(1'b0, 8'h00, 8'h00, q);
    repeat (16) @(posedge clk);
    bus(1'b0, 8'h00, 8'h00, h);
    chk(h, q);
    finish_test();
  end
endmodule

`default_nettype wire
